// ---- rtl/oblcfg_pkg.sv ----
package oblcfg_pkg;

   // register bus and flash address widths
   localparam int REG_AW = 8;
   localparam int FLASH_AW = 16;

   // option byte offsets on the register port
   localparam logic [7:0] OFF_WDT_OSC = 8'h80;
   localparam logic [7:0] OFF_POC = 8'h81;
   localparam logic [7:0] OFF_RSVD_A = 8'h82;
   localparam logic [7:0] OFF_RSVD_B = 8'h83;
   localparam logic [7:0] OFF_DEBUG = 8'h84;
   // own control and status registers
   localparam logic [7:0] OFF_OSC_CTRL = 8'h90;
   localparam logic [7:0] OFF_STATUS = 8'h91;

   // flash locations of the primary and mirror option areas
   localparam logic [15:0] FLASH_PRIMARY_BASE = 16'h0080;
   localparam logic [15:0] FLASH_MIRROR_BASE = 16'h1080;

   // option byte count and indices
   localparam logic [2:0] OPT_COUNT = 3'h5;
   localparam logic [2:0] IDX_WDT = 3'h0;
   localparam logic [2:0] IDX_POC = 3'h1;
   localparam logic [2:0] IDX_DEBUG = 3'h4;

   // field positions in the watchdog / oscillator byte
   localparam int POS_OPEN_LO = 5;
   localparam int POS_RUN = 4;
   localparam int POS_OVF_LO = 1;
   localparam int POS_LOCK = 0;
   // field positions in the other bytes
   localparam int POS_POC_SEL = 0;
   localparam int POS_DBG_LO = 0;
   localparam int POS_OSC_STOP = 1;

   // status register bits
   localparam int POS_ST_DONE = 0;
   localparam int POS_ST_WDT_BAD = 1;
   localparam int POS_ST_DBG_BAD = 2;
   localparam int POS_ST_OSC_RUN = 3;
   localparam int POS_ST_SWAP = 4;

   // reset values
   localparam logic [7:0] OPT_RST = 8'h00;
   localparam logic [7:0] CTRL_RST = 8'h00;

   // watchdog overflow is 2^(base + code) low-speed clocks
   localparam int OVF_BASE_EXP = 10;
   localparam int OVF_CYC_W = 18;

   // loader sequence
   typedef enum logic [2:0] {
      ST_ISSUE,
      ST_WAIT,
      ST_CAPTURE,
      ST_COPY,
      ST_DONE
   } oblcfg_state_t;

endpackage : oblcfg_pkg

// ---- rtl/oblcfg_loader.sv ----
// Local design decision: the strobed register port.
`timescale 1ns/1ps
module oblcfg_loader (
   input wire logic i_clk,
   input wire logic i_arst_n,
   // register port
   input wire logic [oblcfg_pkg::REG_AW-1:0] i_reg_addr,
   input wire logic [7:0] i_reg_wdata,
   input wire logic i_reg_wr,
   input wire logic i_reg_rd,
   output logic [7:0] o_reg_rdata,
   // flash array port
   output logic [oblcfg_pkg::FLASH_AW-1:0] o_flash_addr,
   output logic o_flash_rd,
   output logic o_flash_wr,
   output logic [7:0] o_flash_wdata,
   input wire logic [7:0] i_flash_rdata,
   // flash and system state
   input wire logic i_boot_swap,
   input wire logic i_self_prog,
   input wire logic i_poc_after_chip_erase,
   input wire logic i_halt_mode,
   input wire logic i_stop_mode,
   input wire logic i_aux_timer_lowspeed_sel,
   // configured units
   output logic o_cpu_release,
   output logic [2:0] o_wdt_open_quarters,
   output logic o_wdt_run_enable,
   output logic o_illegal_access_det_en,
   output logic [oblcfg_pkg::OVF_CYC_W-1:0] o_wdt_overflow_cycles,
   output logic o_wdt_count_clk_en,
   output logic o_lowspeed_osc_run,
   output logic o_aux_timer_clk_en,
   output logic o_poweron_clear_dual_threshold,
   output logic o_debug_enable,
   output logic o_debug_erase_on_auth_fail,
   output logic o_option_prohibited
);

   // whole state of the loader
   typedef struct packed {
      oblcfg_pkg::oblcfg_state_t st;
      logic [2:0] idx;
      logic [4:0][7:0] opt;
      logic poc_dual;
      logic swapped;
      logic osc_stop;
      logic done;
      logic flash_rd;
      logic flash_wr;
      logic [oblcfg_pkg::FLASH_AW-1:0] faddr;
      logic [7:0] fwdata;
      logic [7:0] rdata;
   } oblcfg_regs_t;

   oblcfg_regs_t reg_q;
   oblcfg_regs_t reg_d;
   logic rst_meta_q;
   logic rst_sync_n_q;

   // decoded fields from the latched option bytes
   logic [1:0] open_code;
   logic [2:0] ovf_code;
   logic osc_lock;
   logic [1:0] dbg_code;
   logic wdt_bad;
   logic dbg_bad;
   logic osc_run;

   // overflow length in low-speed clocks for a select code
   function automatic logic [oblcfg_pkg::OVF_CYC_W-1:0] ovf_cycles(input logic [2:0] code);
      logic [oblcfg_pkg::OVF_CYC_W-1:0] one;
      one = {{(oblcfg_pkg::OVF_CYC_W-1){1'b0}}, 1'b1};
      ovf_cycles = one << (oblcfg_pkg::OVF_BASE_EXP + int'(code));
   endfunction : ovf_cycles

   // read-back value of a register offset, unmapped reads zero
   function automatic logic [7:0] reg_read(input logic [7:0] addr, input oblcfg_regs_t r,
                                           input logic [7:0] status);
      unique case (addr)
         oblcfg_pkg::OFF_WDT_OSC: reg_read = r.opt[0];
         oblcfg_pkg::OFF_POC: reg_read = r.opt[1];
         oblcfg_pkg::OFF_RSVD_A: reg_read = r.opt[2];
         oblcfg_pkg::OFF_RSVD_B: reg_read = r.opt[3];
         oblcfg_pkg::OFF_DEBUG: reg_read = r.opt[4];
         oblcfg_pkg::OFF_OSC_CTRL: reg_read = {6'h00, r.osc_stop, 1'b0};
         oblcfg_pkg::OFF_STATUS: reg_read = status;
         default: reg_read = 8'h00;
      endcase
   endfunction : reg_read

   // reset release through two flip-flops
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         rst_meta_q <= 1'b0;
         rst_sync_n_q <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_sync_n_q <= rst_meta_q;
      end
   end

   // field decode of the held bytes
   assign open_code = reg_q.opt[oblcfg_pkg::IDX_WDT][oblcfg_pkg::POS_OPEN_LO +: 2];
   assign ovf_code = reg_q.opt[oblcfg_pkg::IDX_WDT][oblcfg_pkg::POS_OVF_LO +: 3];
   assign osc_lock = reg_q.opt[oblcfg_pkg::IDX_WDT][oblcfg_pkg::POS_LOCK];
   assign dbg_code = reg_q.opt[oblcfg_pkg::IDX_DEBUG][oblcfg_pkg::POS_DBG_LO +: 2];
   // flag settings the programmer must not use
   assign wdt_bad = reg_q.done && (ovf_code == 3'h0) && (open_code == 2'h0);
   assign dbg_bad = reg_q.done && (dbg_code == 2'h1);
   // oscillator stops only when unlocked and software asked
   assign osc_run = !(reg_q.osc_stop && !osc_lock);

   // next state of loader, copy and register port
   always_comb begin
      logic [7:0] status;
      logic [oblcfg_pkg::FLASH_AW-1:0] base;
      logic swap_now;
      status = 8'h00;
      base = oblcfg_pkg::FLASH_PRIMARY_BASE;
      swap_now = reg_q.swapped;
      reg_d = reg_q;
      reg_d.flash_rd = 1'b0;
      reg_d.flash_wr = 1'b0;
      status[oblcfg_pkg::POS_ST_DONE] = reg_q.done;
      status[oblcfg_pkg::POS_ST_WDT_BAD] = wdt_bad;
      status[oblcfg_pkg::POS_ST_DBG_BAD] = dbg_bad;
      status[oblcfg_pkg::POS_ST_OSC_RUN] = osc_run;
      status[oblcfg_pkg::POS_ST_SWAP] = reg_q.swapped;
      // swap level taken with the very first read so that read already uses the right area
      if (reg_q.st == oblcfg_pkg::ST_ISSUE && reg_q.idx == 3'h0) begin
         swap_now = i_boot_swap;
      end
      reg_d.swapped = swap_now;
      // boot swap makes the mirror area the one referenced
      if (swap_now) begin
         base = oblcfg_pkg::FLASH_MIRROR_BASE;
      end
      unique case (reg_q.st)
         oblcfg_pkg::ST_ISSUE: begin
            reg_d.faddr = base + {13'h0000, reg_q.idx};
            reg_d.flash_rd = 1'b1;
            reg_d.st = oblcfg_pkg::ST_WAIT;
         end
         oblcfg_pkg::ST_WAIT: begin
            reg_d.st = oblcfg_pkg::ST_CAPTURE;
         end
         oblcfg_pkg::ST_CAPTURE: begin
            // byte is valid one cycle after the read strobe
            reg_d.opt[reg_q.idx] = i_flash_rdata;
            if (reg_q.idx == oblcfg_pkg::IDX_POC) begin
               // mode bit taken only from a chip-erased, programmer-written byte
               reg_d.poc_dual = i_flash_rdata[oblcfg_pkg::POS_POC_SEL] && i_poc_after_chip_erase
                                && !i_self_prog;
            end
            if (reg_q.idx == oblcfg_pkg::OPT_COUNT - 3'h1) begin
               reg_d.st = reg_q.swapped ? oblcfg_pkg::ST_COPY : oblcfg_pkg::ST_DONE;
            end else begin
               reg_d.idx = reg_q.idx + 3'h1;
               reg_d.st = oblcfg_pkg::ST_ISSUE;
            end
         end
         oblcfg_pkg::ST_COPY: begin
            // mirror power-on-clear byte written into the primary location
            reg_d.faddr = oblcfg_pkg::FLASH_PRIMARY_BASE + {13'h0000, oblcfg_pkg::IDX_POC};
            reg_d.fwdata = reg_q.opt[oblcfg_pkg::IDX_POC];
            reg_d.flash_wr = 1'b1;
            reg_d.st = oblcfg_pkg::ST_DONE;
         end
         oblcfg_pkg::ST_DONE: begin
            // fields stay frozen, later flash writes are never re-read
            reg_d.done = 1'b1;
         end
         default: begin
            // unused state codes go back to issuing the read at the current index
            reg_d.st = oblcfg_pkg::ST_ISSUE;
         end
      endcase
      // software oscillator stop request
      if (i_reg_wr && (i_reg_addr == oblcfg_pkg::OFF_OSC_CTRL)) begin
         reg_d.osc_stop = i_reg_wdata[oblcfg_pkg::POS_OSC_STOP];
      end
      // read data stands one cycle after the strobe
      reg_d.rdata = 8'h00;
      if (i_reg_rd) begin
         reg_d.rdata = reg_read(i_reg_addr, reg_q, status);
      end
   end

   // state register, cleared by the synchronised reset
   always_ff @(posedge i_clk or negedge rst_sync_n_q) begin
      if (!rst_sync_n_q) begin
         reg_q.st <= oblcfg_pkg::ST_ISSUE;
         reg_q.idx <= 3'h0;
         reg_q.opt <= {5{oblcfg_pkg::OPT_RST}};
         reg_q.poc_dual <= 1'b0;
         reg_q.swapped <= 1'b0;
         reg_q.osc_stop <= oblcfg_pkg::CTRL_RST[oblcfg_pkg::POS_OSC_STOP];
         reg_q.done <= 1'b0;
         reg_q.flash_rd <= 1'b0;
         reg_q.flash_wr <= 1'b0;
         reg_q.faddr <= {oblcfg_pkg::FLASH_AW{1'b0}};
         reg_q.fwdata <= 8'h00;
         reg_q.rdata <= 8'h00;
      end else begin
         reg_q <= reg_d;
      end
   end

   // register port and flash port outputs
   assign o_reg_rdata = reg_q.rdata;
   assign o_flash_addr = reg_q.faddr;
   assign o_flash_rd = reg_q.flash_rd;
   assign o_flash_wr = reg_q.flash_wr;
   assign o_flash_wdata = reg_q.fwdata;

   // processor held until every option is applied
   assign o_cpu_release = reg_q.done;

   // watchdog configuration, inactive until load completes except the overflow length, which follows the held byte from reset
   assign o_wdt_open_quarters = reg_q.done ? ({1'b0, open_code} + 3'h1) : 3'h0;
   assign o_wdt_run_enable = reg_q.done && reg_q.opt[oblcfg_pkg::IDX_WDT][oblcfg_pkg::POS_RUN];
   assign o_illegal_access_det_en = o_wdt_run_enable;
   assign o_wdt_overflow_cycles = ovf_cycles(ovf_code);
   // count clock: self-programming does not gate it, low-power modes do when unlocked
   assign o_wdt_count_clk_en = o_wdt_run_enable && osc_run
                               && !(!osc_lock && (i_halt_mode || i_stop_mode));

   // low-speed oscillator and aux timer clock
   assign o_lowspeed_osc_run = osc_run;
   assign o_aux_timer_clk_en = osc_run && i_aux_timer_lowspeed_sel;

   // power-on-clear threshold mode
   assign o_poweron_clear_dual_threshold = reg_q.done && reg_q.poc_dual;

   // on-chip debug control
   assign o_debug_enable = reg_q.done && dbg_code[1];
   assign o_debug_erase_on_auth_fail = reg_q.done && (dbg_code == 2'h3);
   assign o_option_prohibited = wdt_bad || dbg_bad;

endmodule : oblcfg_loader

// ---- verification/oblcfg_loader_checker.sv ----
`timescale 1ns/1ps
module oblcfg_loader_checker (
   input wire logic i_clk,
   input wire logic i_arst_n,
   input wire logic i_aux_timer_lowspeed_sel,
   input wire logic [15:0] o_flash_addr,
   input wire logic o_flash_rd,
   input wire logic o_flash_wr,
   input wire logic o_cpu_release,
   input wire logic [2:0] o_wdt_open_quarters,
   input wire logic o_wdt_run_enable,
   input wire logic o_illegal_access_det_en,
   input wire logic [17:0] o_wdt_overflow_cycles,
   input wire logic o_wdt_count_clk_en,
   input wire logic o_lowspeed_osc_run,
   input wire logic o_aux_timer_clk_en,
   input wire logic o_poweron_clear_dual_threshold,
   input wire logic o_debug_enable,
   input wire logic o_debug_erase_on_auth_fail
);
   // one clock domain, checks idle while reset is low
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_arst_n);
   open_range_a:
      assert property (o_cpu_release |-> o_wdt_open_quarters inside {[3'h1:3'h4]}) else $error("open period bad");
   run_detect_a:
      assert property (o_wdt_run_enable == o_illegal_access_det_en) else $error("run and detect differ");
   ovf_pow2_a:
      assert property ($onehot(o_wdt_overflow_cycles) && o_wdt_overflow_cycles >= 18'h00400) else $error("overflow bad");
   count_clk_a:
      assert property (o_wdt_count_clk_en |-> o_wdt_run_enable && o_lowspeed_osc_run) else $error("count clock bad");
   aux_clk_a:
      assert property (o_aux_timer_clk_en == (o_lowspeed_osc_run && i_aux_timer_lowspeed_sel)) else $error("aux clock bad");
   debug_erase_a:
      assert property (o_debug_erase_on_auth_fail |-> o_debug_enable) else $error("erase without debug");
   load_order_a:
      assert property (o_flash_rd |-> !o_cpu_release ##1 (!o_flash_rd) [*2]) else $error("flash read spacing");
   swap_copy_a:
      assert property (o_flash_wr |-> o_flash_addr == 16'h0081 && !o_cpu_release ##1 !o_flash_wr) else $error("copy bad");
   config_hold_a:
      assert property (o_cpu_release |=> o_cpu_release && $stable(o_wdt_overflow_cycles)
         && $stable(o_poweron_clear_dual_threshold) && $stable(o_debug_enable)) else $error("config changed");
   idle_off_a:
      assert property (!o_cpu_release |-> !o_wdt_run_enable && !o_debug_enable) else $error("applied before load");
endmodule : oblcfg_loader_checker
bind oblcfg_loader oblcfg_loader_checker i_chk (.*);

// ---- verification/oblcfg_flash_model.sv ----
`timescale 1ns/1ps
module oblcfg_flash_model (
   input wire logic i_clk,
   input wire logic [15:0] i_addr,
   input wire logic i_rd,
   input wire logic i_wr,
   input wire logic [7:0] i_wdata,
   output logic [7:0] o_rdata
);
   logic [7:0] prim_q [0:4];
   logic [7:0] mirr_q [0:4];
   // byte stands one cycle after the strobe, then the bus toggles
   always @(posedge i_clk) begin
      if (i_rd) begin
         o_rdata <= i_addr[12] ? mirr_q[i_addr[2:0]] : prim_q[i_addr[2:0]];
      end else begin
         o_rdata <= ~o_rdata;
      end
      if (i_wr && i_addr == 16'h0081) begin
         prim_q[1] <= i_wdata;
      end
   end
endmodule : oblcfg_flash_model

// ---- verification/test_oblcfg_loader.sv ----
`timescale 1ns/1ps
module test_oblcfg_loader;
   logic i_clk = 1'b0, i_arst_n = 1'b0, i_reg_wr = 1'b0, i_reg_rd = 1'b0;
   logic [7:0] i_reg_addr = 8'h00, i_reg_wdata = 8'h00, o_reg_rdata, o_flash_wdata, f_rdata;
   logic i_boot_swap = 1'b0, i_self_prog = 1'b0, i_poc_after_chip_erase = 1'b0;
   logic i_halt_mode = 1'b0, i_stop_mode = 1'b0, i_aux_timer_lowspeed_sel = 1'b0;
   logic [15:0] o_flash_addr;
   logic [2:0] o_wdt_open_quarters;
   logic [17:0] o_wdt_overflow_cycles;
   logic o_flash_rd, o_flash_wr, o_cpu_release, o_wdt_run_enable, o_illegal_access_det_en, o_wdt_count_clk_en;
   logic o_lowspeed_osc_run, o_aux_timer_clk_en, o_poweron_clear_dual_threshold, o_debug_enable;
   logic o_debug_erase_on_auth_fail, o_option_prohibited;
   int n_errors = 0;
   int comparisons = 0;
   oblcfg_loader i_dut (.*, .i_flash_rdata(f_rdata));
   oblcfg_flash_model i_flash (.i_clk(i_clk), .i_addr(o_flash_addr), .i_rd(o_flash_rd), .i_wr(o_flash_wr),
      .i_wdata(o_flash_wdata), .o_rdata(f_rdata));
   // 25 MHz clock
   always #20 i_clk = ~i_clk;
   // compare and count
   task chk(input string nm, input logic [17:0] seen, input logic [17:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task stop_test;
      if (n_errors == 0 && comparisons > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : stop_test
   // register port cycles
   task reg_wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge i_clk);
      {i_reg_addr, i_reg_wdata, i_reg_wr} <= {a, d, 1'b1};
      @(posedge i_clk);
      i_reg_wr <= 1'b0;
   endtask : reg_wr
   task reg_rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge i_clk);
      {i_reg_addr, i_reg_rd} <= {a, 1'b1};
      @(posedge i_clk);
      i_reg_rd <= 1'b0;
      #1 chk("reg", o_reg_rdata, exp);
   endtask : reg_rd
   // overflow length from the select code
   function logic [17:0] exp_ovf(input logic [7:0] b);
      return 18'h00001 << (10 + b[3:1]);
   endfunction : exp_ovf
   // hang guard
   initial begin
      #(40 * 10000);
      n_errors++;
      stop_test();
   end
   // random option images, reloads and checks
   initial begin
      logic [7:0] p [0:1][0:4];
      logic [7:0] u [0:4];
      logic stp, lk, osc;
      int w;
      void'($urandom(24));
      for (int it = 0; it < 40; it++) begin
         i_arst_n <= 1'b0;
         for (int k = 0; k < 2; k++) begin
            p[k] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
            // any overflow and window accepted; margin for late interrupts is software's concern
            p[k][0] = (it == 0) ? 8'h00 : (it == 1) ? 8'h30 : 8'($urandom) & 8'h7f;
            p[k][1] = 8'($urandom) & 8'h01;
            p[k][4] = 8'($urandom) & 8'h03;
            for (int j = 0; j < 5; j++) begin
               if (k == 0) i_flash.prim_q[j] = p[0][j];
               else i_flash.mirr_q[j] = p[1][j];
            end
         end
         {i_boot_swap, i_self_prog, i_poc_after_chip_erase} <= 3'($urandom);
         {i_halt_mode, i_stop_mode, i_aux_timer_lowspeed_sel} <= 3'($urandom);
         stp = 1'($urandom);
         repeat (5) @(posedge i_clk);
         i_arst_n <= 1'b1;
         w = 0;
         while (o_cpu_release !== 1'b1 && w < 60) begin
            @(negedge i_clk);
            w++;
         end
         chk("release", o_cpu_release, 1);
         u = p[i_boot_swap];
         lk = u[0][0];
         chk("open", o_wdt_open_quarters, u[0][6:5] + 3'h1);
         chk("run", {o_wdt_run_enable, o_illegal_access_det_en}, {2{u[0][4]}});
         chk("ovf", o_wdt_overflow_cycles, exp_ovf(u[0]));
         chk("poc", o_poweron_clear_dual_threshold, u[1][0] & i_poc_after_chip_erase & !i_self_prog);
         chk("dbg", {o_debug_enable, o_debug_erase_on_auth_fail}, {u[4][1], u[4] == 8'h03});
         chk("bad", o_option_prohibited, (u[0][6:5] == 2'h0 && u[0][3:1] == 3'h0) || u[4] == 8'h01);
         if (i_boot_swap) chk("copy", i_flash.prim_q[1], p[1][1]);
         reg_wr(8'h80, 8'hff);
         for (int k = 0; k < 5; k++) reg_rd(8'h80 + 8'(k), u[k]);
         reg_rd(8'ha0, 8'h00);
         reg_wr(8'h90, {6'h00, stp, 1'b0});
         @(negedge i_clk);
         osc = !(stp & !lk);
         chk("osc", o_lowspeed_osc_run, osc);
         chk("aux", o_aux_timer_clk_en, osc & i_aux_timer_lowspeed_sel);
         chk("cnt", o_wdt_count_clk_en, u[0][4] & osc & !(!lk & (i_halt_mode | i_stop_mode)));
         reg_rd(8'h91, {3'h0, i_boot_swap, osc, u[4] == 8'h01, u[0][6:5] == 2'h0 && u[0][3:1] == 3'h0, 1'b1});
      end
      stop_test();
   end
endmodule : test_oblcfg_loader
